// ---- bench/adccs_mod_model.sv ----
// Behavioural modulator front end that feeds the sequencer a bitstream.
`timescale 1ns/1ps
`default_nettype none
module adccs_mod_model
   import adccs_pkg::*;
#(
   parameter logic [3:0] SHORT_D = 4'h4,
   parameter logic [3:0] REF_D = 4'hC
)
(
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic [1:0] mux_sel_i,
   input wire logic [3:0] in_dens_i,
   output logic bit_o
);
   logic [6:0] tick = 7'h00; // Master clocks within one modulator cycle.
   logic [3:0] acc = 4'h0; // First-order noise-shaping accumulator.
   logic bit_q = 1'b0; // Bit held for a whole modulator cycle.
   logic [3:0] dens; // Ones per sixteen samples of the chosen source.
   logic [4:0] sum;

   // Picks the density of the source that the front end selects.
   always_comb begin
      case (mux_sel_i)
         MUX_SHORT: dens = SHORT_D;
         MUX_REF: dens = REF_D;
         default: dens = in_dens_i;
      endcase
   end

   assign sum = {1'b0, acc} + {1'b0, dens};
   assign bit_o = bit_q;

   // One new bit per 128 enabled clocks, so any 16 samples hold exactly dens ones.
   always @(posedge clk_i) begin
      if (ce_i) begin
         tick <= tick + 7'h01;
         if (tick == MOD_LAST) begin
            acc <= sum[3:0];
            bit_q <= sum[4];
         end
      end
   end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the calibration sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import adccs_pkg::*;
   localparam int P = 64 * 128; // One word period at filter setting 3.
   localparam logic [3:0] DS = 4'h4; // Density of the shorted inputs.
   localparam logic [3:0] DR = 4'hC; // Density of the reference.
   logic clk_i, rst_b_i, ce_i, mod_bit, rd, wr, wait_o, ready_n;
   logic [4:0] addr;
   logic [31:0] wdata, rdata, got, rng;
   logic [3:0] be;
   logic [1:0] mux, gain, g;
   logic [3:0] in_dens; // Density of the analog input.
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   int en_cnt = 0; // Enabled clocks so far.
   int t0;

   adccs_mod_model #(.SHORT_D(DS), .REF_D(DR)) model (.clk_i(clk_i), .ce_i(ce_i),
      .mux_sel_i(mux), .in_dens_i(in_dens), .bit_o(mod_bit));
   adccs_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .mod_bit_i(mod_bit),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
      .word_ready_n_o(ready_n), .mux_sel_o(mux), .gain_o(gain));

   // Free-running 40 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Cycle counters; the plain one cuts a hang short.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (ce_i) begin
         en_cnt <= en_cnt + 1;
      end
      if (cyc == 90000) begin
         err_total++;
         close_out();
      end
   end

   // Next value of the xorshift generator.
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Ones in one word of 64 samples for a density in sixteenths.
   function automatic logic [31:0] ones(input logic [3:0] d);
      return 32'(d) * 32'h40 / 32'h10;
   endfunction

   // Output code of a raw count against the two calibration counts.
   function automatic logic [31:0] code(input logic [31:0] r, z, f, input logic bip);
      if (f <= z) return bip ? 32'(MIDSCALE) : 32'h0;
      if (bip) return 32'h8000 + (r - z) * 32'h7FFF / (f - z);
      return (r - z) * 32'hFFFF / (f - z);
   endfunction

   // Control word at the fastest filter setting.
   function automatic logic [31:0] ctrl(input logic [1:0] m, gs, input logic bip);
      return {25'h0, 2'h3, bip, gs, m};
   endfunction

   // Compares a value and counts the outcome.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One Avalon transfer, held until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] b);
      int n;
      n = 0;
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      be <= b;
      rd <= ~w;
      wr <= w;
      do begin
         @(posedge clk_i);
         n++;
      end while (wait_o !== 1'b0);
      got = rdata;
      chk(32'(n), 32'h2, "bus answer");
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   // Waits until the enabled-clock count reaches a mark.
   task automatic wait_to(input int t);
      while (en_cnt < t) begin
         @(posedge clk_i);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      rst_b_i = 1'b0;
      ce_i = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = 5'h00;
      wdata = 32'h0;
      be = 4'hF;
      in_dens = DS;
      rng = 32'h29;
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      bus(1'b0, ADDR_ZERO, 32'h0, 4'hF);
      chk(got, 32'(ZERO_RST), "zero reset");
      bus(1'b0, ADDR_FULL, 32'h0, 4'hF);
      chk(got, 32'(FULL_RST), "full reset");
      bus(1'b0, 5'h14, 32'h0, 4'hF);
      chk(got, 32'h0, "unmapped read");
      bus(1'b1, 5'h18, 32'hFFFF_FFFF, 4'hF);
      bus(1'b1, ADDR_CTRL, ctrl(MODE_SELF, 2'h1, 1'b0), 4'h0);
      bus(1'b0, ADDR_CTRL, 32'h0, 4'hF);
      chk(got, 32'(MODE_RST), "ignored writes");
      // System zero, then system full in mid-run, then self-calibration.
      rng = xs(rng);
      bus(1'b1, ADDR_CTRL, ctrl(MODE_SYS_ZERO, rng[1:0], 1'b0), 4'hF);
      bus(1'b0, ADDR_STAT, 32'h0, 4'hF);
      chk(32'(got[1]), 32'h1, "sys zero busy");
      chk(32'(mux), 32'(MUX_INPUT), "sys zero source");
      chk(32'(ready_n), 32'h1, "sys zero ready");
      rng = xs(rng);
      repeat (rng[7:0]) @(posedge clk_i);
      bus(1'b1, ADDR_CTRL, ctrl(MODE_SYS_FULL, rng[1:0], 1'b0), 4'hF);
      bus(1'b0, ADDR_CTRL, 32'h0, 4'hF);
      chk(32'(got[1:0]), 32'(MODE_SYS_FULL), "sys full mode");
      chk(32'(mux), 32'(MUX_INPUT), "sys full source");
      rng = xs(rng);
      g = rng[1:0];
      bus(1'b1, ADDR_CTRL, ctrl(MODE_SELF, g, 1'b1), 4'hF);
      t0 = en_cnt;
      wait_to(t0 + 64);
      chk(32'(mux), 32'(MUX_SHORT), "zero source");
      chk(32'(gain), 32'(g), "zero gain");
      bus(1'b0, ADDR_STAT, 32'h0, 4'hF);
      chk(32'(got[7:4]), 32'(ST_ZERO), "zero state");
      wait_to(t0 + 3 * P + 64);
      chk(32'(mux), 32'(MUX_REF), "full source");
      chk(32'(gain), 32'(g), "full gain");
      bus(1'b0, ADDR_ZERO, 32'h0, 4'hF);
      chk(got, ones(DS), "zero result");
      wait_to(t0 + 6 * P - 192);
      bus(1'b0, ADDR_CTRL, 32'h0, 4'hF);
      chk(32'(got[1:0]), 32'(MODE_SELF), "mode held");
      chk(32'(ready_n), 32'h1, "ready held off");
      wait_to(t0 + 6 * P + 64);
      bus(1'b0, ADDR_CTRL, 32'h0, 4'hF);
      chk(32'(got[1:0]), 32'(MODE_NORMAL), "mode cleared");
      bus(1'b0, ADDR_FULL, 32'h0, 4'hF);
      chk(got, ones(DR), "full result");
      chk(32'(mux), 32'(MUX_INPUT), "conversion source");
      // A clock-enable gap stretches the wait by the same count.
      rng = xs(rng);
      ce_i <= 1'b0;
      repeat (32'(rng[4:0]) + 1) @(posedge clk_i);
      ce_i <= 1'b1;
      while (ready_n !== 1'b0 && en_cnt < t0 + 9 * P + 64) begin
         @(posedge clk_i);
      end
      chk(32'(en_cnt - t0 >= 9 * P - 128 && en_cnt - t0 <= 9 * P + 4), 32'h1,
         "ready time");
      // New command while a word waits; ready goes inactive and the held word is kept.
      bus(1'b1, ADDR_CTRL, ctrl(MODE_SYS_ZERO, g, 1'b1), 4'hF);
      t0 = en_cnt;
      wait_to(t0 + 128);
      chk(32'(ready_n), 32'h1, "ready dropped");
      bus(1'b0, ADDR_DATA, 32'h0, 4'hF);
      chk(32'(got[15:0]), code(ones(DS), ones(DS), ones(DR), 1'b1), "midscale");
      close_out();
   end
endmodule
`default_nettype wire

// ---- hdl/adccs_top.sv ----
// Calibration sequencer of a sigma-delta converter with an Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module adccs_top
   import adccs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic mod_bit_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic word_ready_n_o,
   output logic [1:0] mux_sel_o,
   output logic [1:0] gain_o
);

   // Scales a raw word against the calibration points, at 33-bit precision.
   function automatic logic [15:0] cal_code(input logic [9:0] raw, input logic [9:0] zero,
                                            input logic [9:0] full, input logic bip);
      logic signed [32:0] num;
      logic signed [32:0] den;
      logic signed [32:0] q;
      num = $signed({23'h000000, raw}) - $signed({23'h000000, zero});
      den = $signed({23'h000000, full}) - $signed({23'h000000, zero});
      q = 33'sh0_0000_0000;
      if (den > 33'sh0_0000_0000) begin
         q = (num * (bip ? 33'sh0_0000_7FFF : 33'sh0_0000_FFFF)) / den;
      end
      if (bip) begin
         q = q + 33'sh0_0000_8000;
      end
      if (q < 33'sh0_0000_0000) begin
         return 16'h0000;
      end else if (q > 33'sh0_0000_FFFF) begin
         return 16'hFFFF;
      end
      return q[15:0];
   endfunction

   logic rst_meta; // First reset synchroniser stage.
   logic rst_q; // Synchronised active-high run flag (low while in reset).
   logic mod_meta; // First stage of the modulator bit synchroniser.
   logic mod_bit; // Synchronised modulator bit.
   logic [6:0] mod_cnt; // Master clock count within one modulator cycle.
   logic mod_tick; // One-cycle pulse per modulator sample.
   logic [9:0] samp_cnt; // Samples gathered into the current word.
   logic [9:0] acc; // Running sum of modulator ones.
   logic [9:0] acc_word; // Word including the current sample.
   logic period_done; // Last sample of an output-word period.
   logic [1:0] cal_mode; // Calibration mode field.
   logic [1:0] gain_sel; // Selected gain.
   logic bipolar; // Bipolar coding when set.
   logic [1:0] filt_sel; // Filter setting.
   logic [9:0] zero_cal; // Zero-scale calibration point.
   logic [9:0] full_cal; // Full-scale calibration point.
   logic [15:0] data_word; // Last scaled conversion result.
   adccs_state_t state; // Sequencer state.
   logic [1:0] per_cnt; // Periods completed in the current stage.
   logic sys_cal; // Running a system calibration step.
   logic acc_rd; // Read accepted this edge.
   logic acc_wr; // Write accepted this edge.
   logic wr_ctrl; // Accepted write to the control byte.
   logic cal_go; // Calibration command accepted.
   logic zero_end; // Zero-scale stage finishes.
   logic full_end; // Full-scale stage finishes.
   logic conv_end; // Post-calibration conversion finishes.
   logic new_word; // Fresh word enters the data register.
   logic [15:0] code; // Scaled value of the current word.
   logic [31:0] rd_mux; // Read data selected by address.

   // Releases the reset through two flip-flops.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_q <= rst_meta;
      end
   end

   // Brings the modulator bit into the clock domain.
   always_ff @(posedge clk_i or negedge rst_q) begin
      if (!rst_q) begin
         mod_meta <= 1'b0;
         mod_bit <= 1'b0;
      end else if (ce_i) begin
         mod_meta <= mod_bit_i;
         mod_bit <= mod_meta;
      end
   end

   // Bus handshake decode; requests complete when waitrequest is low and the clock is enabled.
   // A master must not finish a transfer while the enable is low, or that transfer is lost.
   assign acc_rd = ce_i && avs_read_i && !avs_waitrequest_o;
   assign acc_wr = ce_i && avs_write_i && !avs_waitrequest_o;
   assign wr_ctrl = acc_wr && (avs_address_i == ADDR_CTRL) && avs_byteenable_i[0];
   // Any non-zero mode code starts a calibration, even mid-conversion.
   assign cal_go = wr_ctrl && (avs_writedata_i[CTRL_MODE_HI -: 2] != MODE_NORMAL);

   // Divides the master clock into modulator cycles.
   assign mod_tick = ce_i && (mod_cnt == MOD_LAST);
   always_ff @(posedge clk_i or negedge rst_q) begin
      if (!rst_q) begin
         mod_cnt <= 7'h00;
      end else if (ce_i) begin
         mod_cnt <= (mod_cnt == MOD_LAST) ? 7'h00 : mod_cnt + 7'h01;
      end
   end

   // Decimates modulator samples into words of the selected length.
   assign acc_word = acc + {9'h000, mod_bit};
   assign period_done = mod_tick && (samp_cnt == dec_ratio(filt_sel) - 10'h001);
   always_ff @(posedge clk_i or negedge rst_q) begin
      if (!rst_q) begin
         samp_cnt <= 10'h000;
         acc <= 10'h000;
      end else if (ce_i) begin
         if (cal_go) begin
            // A command restarts the word so stages align to it.
            samp_cnt <= 10'h000;
            acc <= 10'h000;
         end else if (period_done) begin
            samp_cnt <= 10'h000;
            acc <= 10'h000;
         end else if (mod_tick) begin
            samp_cnt <= samp_cnt + 10'h001;
            acc <= acc_word;
         end
      end
   end

   // Stage completion strobes; a new command cancels them.
   assign zero_end = (state == ST_ZERO) && period_done && (per_cnt == STAGE_LAST) && !cal_go;
   assign full_end = (state == ST_FULL) && period_done && (per_cnt == STAGE_LAST) && !cal_go;
   assign conv_end = (state == ST_CONV) && period_done && !cal_go &&
                     (per_cnt == (sys_cal ? SYS_CONV_LAST : STAGE_LAST));
   assign new_word = conv_end || ((state == ST_RUN) && period_done && !cal_go);
   assign code = cal_code(acc_word, zero_cal, full_cal, bipolar);

   // Walks the calibration stages one output period at a time.
   always_ff @(posedge clk_i or negedge rst_q) begin
      if (!rst_q) begin
         state <= ST_RUN;
         per_cnt <= 2'h0;
         sys_cal <= 1'b0;
      end else if (ce_i) begin
         if (cal_go) begin
            per_cnt <= 2'h0;
            unique case (avs_writedata_i[CTRL_MODE_HI -: 2])
               MODE_SELF: begin
                  state <= ST_ZERO;
                  sys_cal <= 1'b0;
               end
               MODE_SYS_ZERO: begin
                  state <= ST_ZERO;
                  sys_cal <= 1'b1;
               end
               default: begin
                  state <= ST_FULL;
                  sys_cal <= 1'b1;
               end
            endcase
         end else if (zero_end) begin
            state <= sys_cal ? ST_CONV : ST_FULL;
            per_cnt <= 2'h0;
         end else if (full_end || conv_end) begin
            state <= full_end ? ST_CONV : ST_RUN;
            per_cnt <= 2'h0;
         end else if (period_done && (state != ST_RUN)) begin
            per_cnt <= per_cnt + 2'h1;
         end
      end
   end

   // Control fields; hardware clears the mode when calibration ends.
   always_ff @(posedge clk_i or negedge rst_q) begin
      if (!rst_q) begin
         cal_mode <= MODE_RST;
         gain_sel <= GAIN_RST;
         bipolar <= 1'b0;
         filt_sel <= FS_RST;
      end else if (ce_i) begin
         if (wr_ctrl) begin
            // A write in the same cycle as the clear is a new command and wins.
            cal_mode <= avs_writedata_i[CTRL_MODE_HI -: 2];
            gain_sel <= avs_writedata_i[CTRL_GAIN_LO +: 2];
            bipolar <= avs_writedata_i[CTRL_BIPOLAR];
            filt_sel <= avs_writedata_i[CTRL_FS_LO +: 2];
         end else if ((zero_end && sys_cal) || full_end) begin
            cal_mode <= MODE_NORMAL;
         end
      end
   end

   // Stores the calibration points at the end of their stages.
   always_ff @(posedge clk_i or negedge rst_q) begin
      if (!rst_q) begin
         zero_cal <= ZERO_RST;
         full_cal <= FULL_RST;
      end else if (ce_i) begin
         if (zero_end) begin
            zero_cal <= acc_word;
         end
         if (full_end) begin
            full_cal <= acc_word;
         end
      end
   end

   // Data register and word-ready; normal mode leaves calibration alone.
   always_ff @(posedge clk_i or negedge rst_q) begin
      if (!rst_q) begin
         data_word <= 16'h0000;
         word_ready_n_o <= 1'b1;
      end else if (ce_i) begin
         if (cal_go) begin
            word_ready_n_o <= 1'b1;
         end else if (new_word) begin
            data_word <= code;
            word_ready_n_o <= 1'b0;
         end else if (acc_rd && (avs_address_i == ADDR_DATA)) begin
            word_ready_n_o <= 1'b1;
         end
      end
   end

   // Drives the front-end source and gain for the current stage.
   always_ff @(posedge clk_i or negedge rst_q) begin
      if (!rst_q) begin
         mux_sel_o <= MUX_INPUT;
         gain_o <= GAIN_RST;
      end else if (ce_i) begin
         gain_o <= gain_sel;
         if ((state == ST_ZERO) && !sys_cal) begin
            mux_sel_o <= MUX_SHORT;
         end else if ((state == ST_FULL) && !sys_cal) begin
            mux_sel_o <= MUX_REF;
         end else begin
            mux_sel_o <= MUX_INPUT;
         end
      end
   end

   // Selects read data; unmapped addresses read zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address_i)
         ADDR_CTRL: rd_mux = {25'h0000000, filt_sel, bipolar, gain_sel, cal_mode};
         ADDR_STAT: rd_mux = {24'h000000, state, 2'h0, state != ST_RUN, !word_ready_n_o};
         ADDR_DATA: rd_mux = {16'h0000, data_word};
         ADDR_ZERO: rd_mux = {22'h000000, zero_cal};
         ADDR_FULL: rd_mux = {22'h000000, full_cal};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Answers each request one cycle after it appears, then releases.
   always_ff @(posedge clk_i or negedge rst_q) begin
      if (!rst_q) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0000_0000;
      end else if (ce_i) begin
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
         if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= rd_mux;
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_q);

   // Named steps of the calibration sequence.
   sequence s_cmd;
      cal_go;
   endsequence
   sequence s_self_zero_last;
      zero_end && !sys_cal;
   endsequence
   sequence s_self_conv_last;
      conv_end && !sys_cal;
   endsequence

   mod_tick_period_a: assert property (mod_tick && $past(ce_i)
      |-> $past(mod_cnt) == 7'h7E)
      else $error("Modulator tick not spaced by 128 clocks.");
   decim_len_a: assert property (period_done
      |-> samp_cnt + 10'h001 == dec_ratio(filt_sel))
      else $error("Word period does not match decimation ratio.");
   cal_start_ready_a: assert property (s_cmd |=> word_ready_n_o && state != ST_RUN)
      else $error("Calibration command did not start or clear ready.");
   self_short_in_a: assert property ((state == ST_ZERO && !sys_cal) ##1 (state == ST_ZERO)
      |-> mux_sel_o == MUX_SHORT)
      else $error("Self zero-scale stage not on shorted inputs.");
   gain_follow_a: assert property (ce_i |=> gain_o == $past(gain_sel))
      else $error("Front-end gain does not follow selection.");
   self_stage_len_a: assert property (s_self_zero_last
      |=> state == ST_FULL && per_cnt == 2'h0)
      else $error("Self zero stage did not hand over after three periods.");
   mode_clear_a: assert property ((full_end && !wr_ctrl) |=> cal_mode == MODE_NORMAL)
      else $error("Mode field not cleared at calibration end.");
   ready_return_a: assert property (s_self_conv_last
      |=> !word_ready_n_o && state == ST_RUN)
      else $error("Ready did not return after self calibration.");
   zero_store_a: assert property (zero_end |=> zero_cal == $past(acc_word))
      else $error("Zero-scale result not stored.");
   bip_midscale_a: assert property ((bipolar && acc_word == zero_cal && full_cal > zero_cal)
      |-> code == MIDSCALE)
      else $error("Bipolar zero point not at midscale.");

endmodule
`default_nettype wire

// ---- inc/adccs_pkg.sv ----
// Constants, types and helper functions of the calibration sequencer.
// Overview of operation
// - Modulator sample every 128 master clocks.
// - Filter decimates samples to selected word rate.
// - Calibration code write starts calibration anytime.
// - Mode code 0,1 launches self-calibration.
// - Self zero-scale uses internally shorted inputs.
// - Zero-scale conversion uses selected gain.
// - Full-scale converts reference over selected gain.
// - Self-calibration lasts three plus three periods.
// - Mode bits return to 0,0 when done.
// - Word-ready goes inactive until fresh word.
// - Word-ready returns nine periods after self-calibration command.
// - Word-ready deasserts within one modulator cycle.
// - Results go to zero and full registers.
// - Offset and slope computed at 33 bits.
// - Bipolar shorted-input point maps to midscale.
// - Mode code 1,0 launches zero-scale system calibration.
// - Mode code 1,1 launches full-scale system calibration.
package adccs_pkg;

   // Master clock and modulator rate; one sample per MOD_DIV enabled clocks.
   localparam int unsigned MCLK_HZ = 2_457_600;
   localparam int unsigned MOD_RATE_HZ = 19_200;
   localparam int unsigned MOD_DIV = MCLK_HZ / MOD_RATE_HZ;
   localparam logic [6:0] MOD_LAST = 7'(MOD_DIV - 1);

   // Decimation ratios in modulator samples for the four filter settings.
   localparam logic [9:0] DEC_N0 = 10'h3C0;
   localparam logic [9:0] DEC_N1 = 10'h300;
   localparam logic [9:0] DEC_N2 = 10'h0C0;
   // The fastest setting is kept short so a full self-calibration fits a quick run.
   localparam logic [9:0] DEC_N3 = 10'h040;

   // Output-word periods of each calibration stage.
   localparam logic [1:0] STAGE_LAST = 2'h2;
   localparam logic [1:0] SYS_CONV_LAST = 2'h0;

   // Register byte addresses.
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_STAT = 5'h04;
   localparam logic [4:0] ADDR_DATA = 5'h08;
   localparam logic [4:0] ADDR_ZERO = 5'h0C;
   localparam logic [4:0] ADDR_FULL = 5'h10;

   // Control register field positions.
   localparam int unsigned CTRL_MODE_LO = 0;
   localparam int unsigned CTRL_MODE_HI = 1;
   localparam int unsigned CTRL_GAIN_LO = 2;
   localparam int unsigned CTRL_BIPOLAR = 4;
   localparam int unsigned CTRL_FS_LO = 5;

   // Reset values.
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [1:0] GAIN_RST = 2'h0;
   localparam logic [1:0] FS_RST = 2'h0;
   localparam logic [9:0] ZERO_RST = 10'h000;
   localparam logic [9:0] FULL_RST = 10'h3C0;

   // Calibration mode codes.
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_SELF = 2'h1;
   localparam logic [1:0] MODE_SYS_ZERO = 2'h2;
   localparam logic [1:0] MODE_SYS_FULL = 2'h3;

   // Front-end input source codes.
   localparam logic [1:0] MUX_INPUT = 2'h0;
   localparam logic [1:0] MUX_SHORT = 2'h1;
   localparam logic [1:0] MUX_REF = 2'h2;

   // Output code scaling.
   localparam logic [15:0] MIDSCALE = 16'h8000;

   // Sequencer states, one-hot.
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_ZERO = 4'h2,
      ST_FULL = 4'h4,
      ST_CONV = 4'h8
   } adccs_state_t;

   // Returns the decimation ratio for a filter setting.
   function automatic logic [9:0] dec_ratio(input logic [1:0] fs);
      logic [9:0] n;
      n = DEC_N0;
      case (fs)
         2'h1: n = DEC_N1;
         2'h2: n = DEC_N2;
         2'h3: n = DEC_N3;
         default: n = DEC_N0;
      endcase
      return n;
   endfunction

endpackage
